//--- rtl/rspm_top.sv
// reset source selection and power mode control, host register port
// Operation
// - power-fail reset reselected after every power-on
// - software reset reselected after any reset
// - enable bit 2 gates software reset
// - enable bit 1 gates power-fail reset
// - unused enable bits read zero, ignore writes
// - transmitter power saving enabled from reset
// - clearing transmitter bit enters link detection
// - top phy bits 000 enter memory mode
// - memory mode allows only random buffer access
// - shutdown stops clock until power/pin reset
// - io power bit 3 enables activity LED
// - io power bit 2 enables link LED
// - io power bit 1 disables weak pull-ups
// - io power bits 7..4, 0 read zero
// - software reset register bit 2 starts reset
// - selecting unsettled monitor causes system reset
// - clearing oscillator enable stops device responding
// - transmitter power bit 7 disables power saving
`timescale 1ns/100ps
module rspm_top (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic por_cause_in,
   input wire logic supply_ok_in,
   input wire logic [7:0] addr_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out,
   output logic device_reset_out,
   output logic activity_led_on_out,
   output logic link_led_on_out,
   output logic pullup_on_out,
   output logic supply_monitor_on_out,
   output logic sysclk_on_out,
   output logic tx_on_out,
   output logic rx_on_out,
   output logic tx_powersave_out,
   output logic auto_ptr_on_out,
   output rspm_pkg::rspm_mode_t mode_out
);
   import rspm_pkg::*;

   // ************************************************************
   // storage
   // ************************************************************
   logic [7:0] rst_enable_reg; // reset_source_enable
   logic [7:0] io_power_reg; // io_power_control
   logic [7:0] phy_ctrl_reg; // phy_control
   logic mon_on_reg; // supply_monitor_on
   logic osc_on_reg; // osc_output_on
   logic psoff_reg; // tx_powersave_off
   logic first_reg; // high only in the first cycle after release
   logic [2:0] supply_sync_reg; // three-stage supply_ok synchroniser
   logic supply_ok_reg; // debounced supply state
   logic [MON_CNT_W-1:0] mon_cnt_reg; // cycles since monitor enable
   logic sw_fire; // software reset command accepted
   logic pf_fire; // power-fail reset condition
   logic mon_settled; // monitor past its turn-on time
   logic wr_ok; // write that the clocked logic still sees
   rspm_mode_if mif ();

   // decoder for modes; kept separate so the mode table is one place
   rspm_mode_dec u_dec (
      .mif(mif.dec)
   );

   assign mif.phy_ctrl = phy_ctrl_reg;
   assign mif.osc_on = osc_on_reg;
   assign mif.powersave_off = psoff_reg;

   // once the oscillator is cut the device stops answering the host
   assign wr_ok = wr_in && osc_on_reg;

   // ************************************************************
   // reset cause capture
   // ************************************************************
   // the cause level is sampled after release, never loaded by reset
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         first_reg <= 1'b1;
      end else begin
         first_reg <= 1'b0;
      end
   end

   // ************************************************************
   // reset_source_enable register
   // ************************************************************
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         // software source selected after any reset
         rst_enable_reg <= RESET_SOURCE_ENABLE_RESET;
      end else if (first_reg && por_cause_in) begin
         // power-on also reselects the power-fail source
         rst_enable_reg[RESET_SOURCE_ENABLE_PF_BIT] <= 1'b1;
      end else if (wr_ok && addr_in == ADDR_RST_ENABLE) begin
         // only the two live bits store
         rst_enable_reg <= wdata_in & RESET_SOURCE_ENABLE_MASK;
      end
   end

   // ************************************************************
   // io_power_control register
   // ************************************************************
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         io_power_reg <= IO_POWER_CONTROL_RESET;
      end else if (wr_ok && addr_in == ADDR_IO_POWER) begin
         // bits 7..4 and reserved bit 0 never store
         io_power_reg <= wdata_in & IO_POWER_CONTROL_MASK;
      end
   end

   // ************************************************************
   // phy, transmitter power and oscillator controls
   // ************************************************************
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         phy_ctrl_reg <= PHY_RESET;
         psoff_reg <= TX_POWER_CONTROL_RESET[TX_POWER_CONTROL_PSOFF_BIT];
         osc_on_reg <= 1'b1;
      end else if (wr_ok) begin
         if (addr_in == ADDR_PHY_CTRL) begin
            phy_ctrl_reg <= wdata_in;
         end
         if (addr_in == ADDR_TX_POWER) begin
            psoff_reg <= wdata_in[TX_POWER_CONTROL_PSOFF_BIT];
         end
         if (addr_in == ADDR_OSC_POWER) begin
            // once cleared, only a reset brings the clock back
            osc_on_reg <= wdata_in[OSC_OE_BIT];
         end
      end
   end

   // ************************************************************
   // supply monitor enable and settle timer
   // ************************************************************
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mon_on_reg <= 1'b0;
      end else if (first_reg && por_cause_in) begin
         mon_on_reg <= 1'b1;
      end else if (wr_ok && addr_in == ADDR_SUPPLY_MON) begin
         mon_on_reg <= wdata_in[SMON_EN_BIT];
      end
   end

   // counts up while enabled; a disable restarts the settle wait
   // the power-on load comes first: the enable is still low in that cycle
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mon_cnt_reg <= '0;
      end else if (first_reg && por_cause_in) begin
         // at power-on the monitor has been running all along
         mon_cnt_reg <= MON_CNT_W'(MON_TURN_ON_CYC);
      end else if (!mon_on_reg) begin
         mon_cnt_reg <= '0;
      end else if (!mon_settled) begin
         mon_cnt_reg <= mon_cnt_reg + MON_CNT_W'(1);
      end
   end

   assign mon_settled = mon_cnt_reg == MON_CNT_W'(MON_TURN_ON_CYC);

   // ************************************************************
   // supply_ok synchroniser
   // ************************************************************
   // the pin is async; a change counts once stages two and three agree
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         supply_sync_reg <= 3'b111;
         supply_ok_reg <= 1'b1;
      end else begin
         supply_sync_reg <= {supply_sync_reg[1:0], supply_ok_in};
         if (supply_sync_reg[1] == supply_sync_reg[2]) begin
            supply_ok_reg <= supply_sync_reg[2];
         end
      end
   end

   // ************************************************************
   // reset request generation
   // ************************************************************
   // software command only acts while its source is selected
   assign sw_fire = wr_ok && addr_in == ADDR_SW_RESET &&
                    wdata_in[SW_RESET_COMMAND_GO_BIT] &&
                    rst_enable_reg[RESET_SOURCE_ENABLE_SW_BIT];

   // a fault only resets while selected; an unsettled monitor that is
   // selected reads as a fault, so selecting it early resets the chip
   assign pf_fire = rst_enable_reg[RESET_SOURCE_ENABLE_PF_BIT] &&
                    (!mon_on_reg || !mon_settled ||
                     !supply_ok_reg);

   // deselection gates the request only; monitor state is untouched
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         device_reset_out <= 1'b0;
      end else begin
         device_reset_out <= sw_fire | (pf_fire & mon_on_reg &
                             !first_reg);
      end
   end

   // ************************************************************
   // registered outputs
   // ************************************************************
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         activity_led_on_out <= 1'b0;
         link_led_on_out <= 1'b0;
         pullup_on_out <= 1'b1;
         supply_monitor_on_out <= 1'b0;
         sysclk_on_out <= 1'b1;
         tx_on_out <= 1'b0;
         rx_on_out <= 1'b0;
         tx_powersave_out <= 1'b0;
         auto_ptr_on_out <= 1'b0;
         mode_out <= MODE_MEMORY;
      end else begin
         // secondary functions are dropped too in shutdown
         activity_led_on_out <= io_power_reg[IO_POWER_CONTROL_ACT_BIT] &&
                                osc_on_reg;
         link_led_on_out <= io_power_reg[IO_POWER_CONTROL_LINK_BIT] &&
                            osc_on_reg;
         pullup_on_out <= !io_power_reg[IO_POWER_CONTROL_PUD_BIT];
         supply_monitor_on_out <= mon_on_reg;
         sysclk_on_out <= osc_on_reg;
         tx_on_out <= mif.tx_on;
         rx_on_out <= mif.rx_on;
         tx_powersave_out <= mif.tx_powersave;
         auto_ptr_on_out <= mif.auto_ptr_on;
         mode_out <= mif.mode;
      end
   end

   // ************************************************************
   // register read port
   // ************************************************************
   // reads land one cycle after rd_in; unmapped offsets read zero
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in && osc_on_reg) begin
         unique case (addr_in)
            ADDR_RST_ENABLE: rdata_out <= rst_enable_reg;
            ADDR_IO_POWER: rdata_out <= io_power_reg;
            ADDR_PHY_CTRL: rdata_out <= phy_ctrl_reg;
            ADDR_TX_POWER: rdata_out <= {psoff_reg, 7'h00};
            ADDR_OSC_POWER: rdata_out <= OSC_FIXED | {7'h00, osc_on_reg};
            ADDR_SUPPLY_MON: rdata_out <= {mon_on_reg, supply_ok_reg, 6'h00};
            default: rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end
endmodule

//--- rtl/rspm_pkg.sv
// package: register map, field positions and timing for the reset/power block
package rspm_pkg;
   // ************************************************************
   // register offsets on the internal host register port
   // ************************************************************
   localparam logic [7:0] ADDR_SUPPLY_MON = 8'h13; // supply_monitor_control
   localparam logic [7:0] ADDR_IO_POWER = 8'h70; // io_power_control
   localparam logic [7:0] ADDR_RST_ENABLE = 8'h72; // reset_source_enable
   localparam logic [7:0] ADDR_SW_RESET = 8'h75; // sw_reset_command
   localparam logic [7:0] ADDR_PHY_CTRL = 8'h78; // phy_control
   localparam logic [7:0] ADDR_OSC_POWER = 8'h7c; // osc_power_control
   localparam logic [7:0] ADDR_TX_POWER = 8'h7d; // tx_power_control

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int RESET_SOURCE_ENABLE_SW_BIT = 2; // sw_reset_select
   localparam int RESET_SOURCE_ENABLE_PF_BIT = 1; // power_fail_reset_select
   localparam int IO_POWER_CONTROL_ACT_BIT = 3; // activity_led_on
   localparam int IO_POWER_CONTROL_LINK_BIT = 2; // link_led_on
   localparam int IO_POWER_CONTROL_PUD_BIT = 1; // pullup_disable
   localparam int SW_RESET_COMMAND_GO_BIT = 2; // sw_reset_command start bit
   localparam int PHY_EN_BIT = 7; // physical layer enable
   localparam int PHY_TX_BIT = 6; // transmitter_on
   localparam int PHY_RX_BIT = 5; // receiver enable
   localparam int SMON_EN_BIT = 7; // supply_monitor_on
   localparam int SMON_STAT_BIT = 6; // supply status readback
   localparam int OSC_OE_BIT = 0; // osc_output_on
   localparam int TX_POWER_CONTROL_PSOFF_BIT = 7; // tx_powersave_off

   // ************************************************************
   // reset values and fixed read patterns
   // ************************************************************
   localparam logic [7:0] RESET_SOURCE_ENABLE_RESET = 8'h04;
   localparam logic [7:0] IO_POWER_CONTROL_RESET = 8'h00;
   localparam logic [7:0] PHY_RESET = 8'h00;
   localparam logic [7:0] TX_POWER_CONTROL_RESET = 8'h00;
   localparam logic [7:0] RESET_SOURCE_ENABLE_MASK = 8'h06; // only bits 2 and 1 live
   localparam logic [7:0] IO_POWER_CONTROL_MASK = 8'h0e; // only bits 3..1 live
   localparam logic [7:0] OSC_FIXED = 8'h12; // reserved 100b, bit 1 one

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_HZ = 20_000_000;
   localparam int MON_TURN_ON_US = 100; // supply monitor settling time
   localparam int MON_TURN_ON_CYC = (MON_TURN_ON_US * CLK_HZ + 999_999)
                                    / 1_000_000;
   localparam int MON_CNT_W = $clog2(MON_TURN_ON_CYC + 1);

   // ************************************************************
   // power modes, one-hot
   // ************************************************************
   typedef enum logic [3:0] {
      MODE_NORMAL = 4'b0001,
      MODE_LINK_DETECT = 4'b0010,
      MODE_MEMORY = 4'b0100,
      MODE_SHUTDOWN = 4'b1000
   } rspm_mode_t;
endpackage

//--- rtl/rspm_mode_if.sv
// interface: control bits into the mode decoder and its decoded enables
`timescale 1ns/100ps
interface rspm_mode_if;
   import rspm_pkg::*;
   logic [7:0] phy_ctrl; // phy_control register value
   logic osc_on; // oscillator output still routed
   logic powersave_off; // tx_powersave_off bit
   rspm_mode_t mode; // decoded power mode
   logic tx_on; // transmitter and link pulses alive
   logic rx_on; // receiver alive
   logic tx_powersave; // tri-state driver when idle
   logic auto_ptr_on; // automatic pointer interfaces usable

   modport ctrl (output phy_ctrl, output osc_on, output powersave_off,
                 input mode, input tx_on, input rx_on,
                 input tx_powersave, input auto_ptr_on);
   modport dec (input phy_ctrl, input osc_on, input powersave_off,
                output mode, output tx_on, output rx_on,
                output tx_powersave, output auto_ptr_on);
endinterface

//--- rtl/rspm_mode_dec.sv
// power mode decoder: turns control bits into mode and physical enables
`timescale 1ns/100ps
module rspm_mode_dec (
   rspm_mode_if.dec mif
);
   import rspm_pkg::*;

   // ************************************************************
   // mode classification
   // ************************************************************
   // shutdown outranks everything: with the clock gone nothing else runs
   always_comb begin
      if (!mif.osc_on) begin
         mif.mode = MODE_SHUTDOWN;
      end else if (mif.phy_ctrl[7:5] == 3'b000) begin
         mif.mode = MODE_MEMORY;
      end else if (!mif.phy_ctrl[PHY_TX_BIT]) begin
         mif.mode = MODE_LINK_DETECT;
      end else begin
         mif.mode = MODE_NORMAL;
      end
   end

   // ************************************************************
   // physical-layer enables per mode
   // ************************************************************
   always_comb begin
      mif.tx_on = 1'b0;
      mif.rx_on = 1'b0;
      mif.tx_powersave = 1'b0;
      mif.auto_ptr_on = 1'b0;
      unique case (mif.mode)
         MODE_NORMAL: begin
            mif.tx_on = mif.phy_ctrl[PHY_EN_BIT];
            mif.rx_on = mif.phy_ctrl[PHY_EN_BIT] & mif.phy_ctrl[PHY_RX_BIT];
            // power saving on unless software turned it off
            mif.tx_powersave = !mif.powersave_off;
            mif.auto_ptr_on = 1'b1;
         end
         MODE_LINK_DETECT: begin
            // transmitter and link pulse generator stay dead
            mif.tx_on = 1'b0;
            mif.rx_on = mif.phy_ctrl[PHY_EN_BIT] & mif.phy_ctrl[PHY_RX_BIT];
            mif.auto_ptr_on = 1'b1;
         end
         MODE_MEMORY: begin
            // only random access to the buffers survives
            mif.auto_ptr_on = 1'b0;
         end
         MODE_SHUTDOWN: begin
            mif.auto_ptr_on = 1'b0;
         end
         default: begin
            mif.auto_ptr_on = 1'b0;
         end
      endcase
   end
endmodule

//--- tb/rspm_top_assertions.sv
// checker: port-level properties of the reset and power mode block
`timescale 1ns/100ps
module rspm_top_assertions
   import rspm_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] addr_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] wdata_in,
   input wire logic [7:0] rdata_out,
   input wire logic device_reset_out,
   input wire logic activity_led_on_out,
   input wire logic link_led_on_out,
   input wire logic pullup_on_out,
   input wire logic supply_monitor_on_out,
   input wire logic sysclk_on_out,
   input wire logic tx_on_out,
   input wire logic rx_on_out,
   input wire logic auto_ptr_on_out,
   input wire rspm_pkg::rspm_mode_t mode_out
);
   // ************************************************************
   // helper shadow of the software reset select
   // ************************************************************
   logic sw_sel_reg; // follows host writes to the enable register
   logic wr_ok; // a write the block will take
   assign wr_ok = wr_in && sysclk_on_out;
   // shadow resets to selected, like the block after any reset
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sw_sel_reg <= 1'b1;
      end else if (wr_ok && addr_in == ADDR_RST_ENABLE) begin
         sw_sel_reg <= wdata_in[RESET_SOURCE_ENABLE_SW_BIT];
      end
   end
   // ************************************************************
   // properties
   // ************************************************************
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   reset_source_enable_read_a: assert property (rd_in && addr_in == ADDR_RST_ENABLE
      |=> (rdata_out & ~RESET_SOURCE_ENABLE_MASK) == 8'h00) else $error("enable pad bits");
   io_power_control_read_a: assert property (rd_in && addr_in == ADDR_IO_POWER
      |=> (rdata_out & ~IO_POWER_CONTROL_MASK) == 8'h00) else $error("io pad bits");
   sw_go_a: assert property (wr_ok && addr_in == ADDR_SW_RESET
      && wdata_in[SW_RESET_COMMAND_GO_BIT] && sw_sel_reg |=> device_reset_out
      ##1 !device_reset_out) else $error("soft reset pulse");
   sw_block_a: assert property (wr_ok && addr_in == ADDR_SW_RESET
      && !sw_sel_reg && !supply_monitor_on_out |=> !device_reset_out [*3])
      else $error("soft reset not gated");
   led_follow_a: assert property (wr_ok && addr_in == ADDR_IO_POWER
      |=> ##1 activity_led_on_out == $past(wdata_in[IO_POWER_CONTROL_ACT_BIT], 2)
      && link_led_on_out == $past(wdata_in[IO_POWER_CONTROL_LINK_BIT], 2))
      else $error("led enables");
   pullup_follow_a: assert property (wr_ok && addr_in == ADDR_IO_POWER
      |=> ##1 pullup_on_out != $past(wdata_in[IO_POWER_CONTROL_PUD_BIT], 2))
      else $error("pull-up control");
   mem_mode_a: assert property (wr_ok && addr_in == ADDR_PHY_CTRL
      && wdata_in[7:5] == 3'b000 |=> ##1 mode_out == MODE_MEMORY
      && !tx_on_out && !rx_on_out && !auto_ptr_on_out)
      else $error("memory mode");
   link_det_a: assert property (wr_ok && addr_in == ADDR_PHY_CTRL
      && wdata_in[7:5] != 3'b000 && !wdata_in[PHY_TX_BIT]
      |=> ##1 mode_out == MODE_LINK_DETECT && !tx_on_out)
      else $error("link detect mode");
   shut_hold_a: assert property (!sysclk_on_out |-> mode_out == MODE_SHUTDOWN
      && !activity_led_on_out ##1 !sysclk_on_out && rdata_out == 8'h00)
      else $error("shutdown not held");
endmodule

//--- tb/rspm_host.sv
// host model: single byte writes and reads on the register port
`timescale 1ns/100ps
module rspm_host (
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   output logic [7:0] addr_out,
   output logic wr_out,
   output logic rd_out,
   output logic [7:0] wdata_out
);
   // idle bus from time zero
   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // one strobe cycle; released lines flip so stale data cannot match
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask
   // read data is taken just after the edge that saw the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      #1 v = rdata_in;
   endtask
endmodule

//--- tb/rspm_top_tb.sv
// testbench: reset sources, io power and power modes of the block
`timescale 1ns/100ps
module rspm_top_tb;
   import rspm_pkg::*;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0; // reset held from time zero
   logic por_cause_in = 1'b1;
   logic supply_ok_in = 1'b1;
   logic [7:0] addr_in, wdata_in, rdata_out, v;
   logic wr_in, rd_in, device_reset_out, activity_led_on_out;
   logic link_led_on_out, pullup_on_out, supply_monitor_on_out, hit;
   logic sysclk_on_out, tx_on_out, rx_on_out, tx_powersave_out;
   logic auto_ptr_on_out;
   rspm_mode_t mode_out;
   int errors = 0;
   int n_checks = 0;
   always #25 clk_in = ~clk_in; // 20 MHz
   rspm_top u_rspm_top (.clk_in, .arst_n_in, .por_cause_in, .supply_ok_in,
      .addr_in, .wr_in, .rd_in, .wdata_in, .rdata_out, .device_reset_out,
      .activity_led_on_out, .link_led_on_out, .pullup_on_out,
      .supply_monitor_on_out, .sysclk_on_out, .tx_on_out, .rx_on_out,
      .tx_powersave_out, .auto_ptr_on_out, .mode_out);
   rspm_host u_rspm_host (.clk_in, .rdata_in(rdata_out), .addr_out(addr_in),
      .wr_out(wr_in), .rd_out(rd_in), .wdata_out(wdata_in));
   // ************************************************************
   // shared helpers
   // ************************************************************
   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // pin reset, then two edges before the first request
   task automatic pin_reset(input logic por, input int n);
      @(posedge clk_in);
      arst_n_in <= 1'b0;
      por_cause_in <= por;
      repeat (n) @(posedge clk_in);
      arst_n_in <= 1'b1;
      step(2);
   endtask
   // bounded wait for a reset request
   task automatic wait_dr(input int n);
      hit = 1'b0;
      for (int i = 0; i < n && hit !== 1'b1; i++) begin
         step(1);
         hit = (device_reset_out === 1'b1);
      end
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_por();
      u_rspm_host.rd_reg(ADDR_RST_ENABLE, v);
      chk("enable after power-on", v, 8'h06);
      u_rspm_host.wr_reg(ADDR_RST_ENABLE, 8'hff);
      u_rspm_host.rd_reg(ADDR_RST_ENABLE, v);
      chk("enable pad bits", v, 8'h06);
      chk("pull-ups at reset", {7'h0, pullup_on_out}, 8'h01);
      $display("test power-on defaults done");
   endtask
   task automatic t_pf();
      @(posedge clk_in);
      supply_ok_in <= 1'b0;
      wait_dr(8);
      chk("power-fail reset", {7'h0, hit}, 8'h01);
      @(posedge clk_in);
      supply_ok_in <= 1'b1;
      step(8);
      u_rspm_host.wr_reg(ADDR_RST_ENABLE, 8'h04);
      @(posedge clk_in);
      supply_ok_in <= 1'b0;
      step(10);
      chk("deselected fail", {7'h0, device_reset_out}, 8'h00);
      u_rspm_host.rd_reg(ADDR_SUPPLY_MON, v);
      chk("monitor untouched", v, 8'h80);
      @(posedge clk_in);
      supply_ok_in <= 1'b1;
      step(6);
      $display("test power-fail done");
   endtask
   task automatic t_io();
      // pull-ups go off only while the bench drives every pin
      u_rspm_host.wr_reg(ADDR_IO_POWER, 8'h0e);
      step(1);
      chk("io outputs", {5'h0, activity_led_on_out, link_led_on_out,
          pullup_on_out}, 8'h06);
      u_rspm_host.wr_reg(ADDR_IO_POWER, 8'hf0);
      u_rspm_host.rd_reg(ADDR_IO_POWER, v);
      chk("io pad bits", v, 8'h00);
      $display("test io power done");
   endtask
   task automatic t_modes();
      u_rspm_host.wr_reg(ADDR_PHY_CTRL, 8'he0);
      step(1);
      chk("normal", {1'b0, tx_powersave_out, mode_out, tx_on_out, rx_on_out},
          8'h47);
      u_rspm_host.wr_reg(ADDR_TX_POWER, 8'h80);
      step(1);
      chk("saving off", {7'h0, tx_powersave_out}, 8'h00);
      u_rspm_host.wr_reg(ADDR_PHY_CTRL, 8'ha0);
      step(1);
      chk("link detect", {2'h0, mode_out, tx_on_out, rx_on_out},
          8'h09);
      u_rspm_host.wr_reg(ADDR_PHY_CTRL, 8'h00);
      step(1);
      chk("memory", {2'h0, mode_out, rx_on_out, auto_ptr_on_out},
          8'h10);
      u_rspm_host.wr_reg(ADDR_PHY_CTRL, 8'he0);
      step(1);
      chk("back normal", {3'h0, mode_out, auto_ptr_on_out},
          8'h03);
      $display("test power modes done");
   endtask
   task automatic t_shut();
      u_rspm_host.wr_reg(ADDR_PHY_CTRL, 8'h00);
      u_rspm_host.wr_reg(ADDR_IO_POWER, 8'h00);
      u_rspm_host.wr_reg(ADDR_SUPPLY_MON, 8'h00);
      u_rspm_host.wr_reg(ADDR_OSC_POWER, 8'h00);
      step(1);
      chk("shutdown", {3'h0, sysclk_on_out, mode_out}, 8'h08);
      u_rspm_host.rd_reg(ADDR_RST_ENABLE, v);
      chk("no answer", v, 8'h00);
      pin_reset(1'b0, 300);
      chk("pin reset", {6'h0, sysclk_on_out, supply_monitor_on_out},
          8'h02);
      u_rspm_host.rd_reg(ADDR_RST_ENABLE, v);
      chk("enable after pin", v, 8'h04);
      $display("test shutdown done");
   endtask
   task automatic t_sw();
      u_rspm_host.wr_reg(ADDR_SW_RESET, 8'h04);
      #1;
      chk("soft reset", {7'h0, device_reset_out}, 8'h01);
      step(1);
      chk("soft reset end", {7'h0, device_reset_out}, 8'h00);
      u_rspm_host.wr_reg(ADDR_RST_ENABLE, 8'h00);
      u_rspm_host.wr_reg(ADDR_SW_RESET, 8'h04);
      step(2);
      chk("soft gated", {7'h0, device_reset_out}, 8'h00);
      $display("test software reset done");
   endtask
   task automatic t_unsettled();
      u_rspm_host.wr_reg(ADDR_SUPPLY_MON, 8'h80);
      u_rspm_host.wr_reg(ADDR_RST_ENABLE, 8'h06);
      wait_dr(8);
      chk("unsettled select", {7'h0, hit}, 8'h01);
      step(2010);
      chk("settled", {7'h0, device_reset_out}, 8'h00);
      $display("test monitor settling done");
   endtask
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      repeat (5) @(posedge clk_in);
      arst_n_in <= 1'b1;
      step(2);
      t_por();
      t_pf();
      t_io();
      t_modes();
      t_shut();
      t_sw();
      t_unsettled();
      print_verdict();
   end
   // the run needs about 2400 cycles; a hang is cut off well after
   initial begin
      repeat (20000) @(posedge clk_in);
      errors++;
      print_verdict();
   end
endmodule
bind rspm_top rspm_top_assertions u_chk (.clk_in, .arst_n_in, .addr_in,
   .wr_in, .rd_in, .wdata_in, .rdata_out, .device_reset_out,
   .activity_led_on_out, .link_led_on_out, .pullup_on_out,
   .supply_monitor_on_out, .sysclk_on_out, .tx_on_out, .rx_on_out,
   .auto_ptr_on_out, .mode_out);
